//--- hw/ifpc_pkg.sv
/*
 Package for the IF processor control port: port addresses, widths,
 reset values and timing counts.
 Assumes a 250 MHz system clock.
*/
package ifpc_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SER_HALF_NS = 40;
  localparam int SER_HALF_CYC = (SER_HALF_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int SYN_BITS = 24;
  localparam int RELAY_PULSE_NS = 10000;
  localparam int RELAY_PULSE_CYC = RELAY_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [2:0] PORT_SYN_DATA = 3'h0;
  localparam logic [2:0] PORT_SYN_GO = 3'h1;
  localparam logic [2:0] PORT_RELAY_SET = 3'h2;
  localparam logic [2:0] PORT_RELAY_CLR = 3'h3;
  localparam logic [2:0] PORT_LED_LO = 3'h4;
  localparam logic [2:0] PORT_LED_HI = 3'h5;
  localparam logic [2:0] PORT_SWITCH = 3'h6;
  localparam logic [2:0] PORT_DETECT = 3'h7;
  localparam logic [2:0] RB_LOCK = 3'h0;
  localparam logic [2:0] RB_RELAY_SET = 3'h1;
  localparam logic [2:0] RB_RELAY_CLR = 3'h2;
  localparam logic [2:0] RB_LED_LO = 3'h3;
  localparam logic [2:0] RB_LED_HI = 3'h4;
  localparam logic [2:0] RB_SRC = 3'h5;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [23:0] SHIFT_RESET = 24'h00_0000;
  localparam logic [1:0] SRC_A = 2'h0;
  localparam logic [1:0] SRC_B = 2'h1;
  localparam logic [1:0] SRC_TEST = 2'h2;
  localparam logic [1:0] SRC_ZERO = 2'h3;
  localparam int RLY_MODE = 0;
  localparam int RLY_SRC0 = 1;
  localparam int RLY_SRC1 = 2;
  localparam int RLY_SEC_A0 = 3;
  localparam int RLY_SEC_A1 = 4;
  localparam int RLY_SEC_A2 = 5;
  typedef enum logic [1:0] {IFPC_IDLE, IFPC_LOW, IFPC_HIGH, IFPC_LOAD}
    ifpc_ser_t;
endpackage : ifpc_pkg

//--- hw/ifpc_ser.sv
/*
 One synthesizer serial stream: shifts a word MSB first, then pulses
 the load enable. Assumes same-clock start pulse and word.
*/
`timescale 1ns/1ps
module ifpc_ser import ifpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [SYN_BITS-1:0] word,
  output logic busy,
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load
);
  ifpc_ser_t state_reg;
  logic [SYN_BITS-1:0] shift_reg;
  logic [7:0] bit_reg;
  logic [7:0] tick_reg;
  logic tick_end;

  assign tick_end = tick_reg == 8'(SER_HALF_CYC - 1);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tick_reg <= 8'h00;
    end else if (state_reg == IFPC_IDLE || tick_end) begin
      tick_reg <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= IFPC_IDLE;
      shift_reg <= SHIFT_RESET;
      bit_reg <= 8'h00;
      ser_clk <= 1'b0;
      ser_data <= 1'b0;
      ser_load <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state_reg)
        IFPC_IDLE: begin
          ser_load <= 1'b0;
          if (start) begin
            state_reg <= IFPC_LOW;
            shift_reg <= word;
            bit_reg <= 8'(SYN_BITS);
            ser_data <= word[SYN_BITS-1];
            busy <= 1'b1;
          end else begin
            busy <= 1'b0;
          end
        end
        IFPC_LOW: if (tick_end) begin
          ser_clk <= 1'b1;
          state_reg <= IFPC_HIGH;
        end
        IFPC_HIGH: if (tick_end) begin
          ser_clk <= 1'b0;
          shift_reg <= {shift_reg[SYN_BITS-2:0], 1'b0};
          ser_data <= shift_reg[SYN_BITS-2];
          bit_reg <= bit_reg - 8'h01;
          state_reg <= (bit_reg == 8'h01) ? IFPC_LOAD : IFPC_LOW;
        end
        IFPC_LOAD: if (tick_end) begin
          ser_load <= ~ser_load;
          if (ser_load) begin
            state_reg <= IFPC_IDLE;
          end
        end
        default: state_reg <= IFPC_IDLE;
      endcase
    end
  end
endmodule : ifpc_ser

//--- hw/ifpc_port.sv
/*
 IF processor control port: 8-bit strobed parallel bus, 3-bit port
 address, four synthesizer streams, latching relay pairs, lamps, and
 readback. Assumes host pins are asynchronous to sys_clk.
*/
// Function
// - 8-bit data, strobe, 3-bit address selects port
// - Ports control four synthesizers and eight relays
// - Reserved ports for lamps, switches, detector
// - Four serial streams: clock, data, load
// - Eight set/reset relay drive pairs
// - Readback lock bits and relay indicator pairs
// - Sixteen lamps show lock, source and user bits
// - Per-oscillator lamp lit on loss of lock
// - Oscillator frequency set only via host
// - Mode relay picks seven-beam or dual-channel
// - Source relays pick A, B, test, zero
// - Narrow unit per-section choice, wide per-box
// - Wide unit lights one of five lamps
// - Narrow unit two lamps per output, three box
`timescale 1ns/1ps
module ifpc_port import ifpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [7:0] host_data,
  input wire logic [2:0] host_addr,
  input wire logic host_strobe,
  input wire logic [2:0] rd_sel,
  input wire logic narrow_unit,
  input wire logic [3:0] pll_lock,
  input wire logic [7:0] relay_ind_set,
  input wire logic [7:0] relay_ind_clr,
  output logic [7:0] rd_data,
  output logic [3:0] syn_clk,
  output logic [3:0] syn_data,
  output logic [3:0] syn_load,
  output logic [7:0] relay_set,
  output logic [7:0] relay_clr,
  output logic [15:0] lamp,
  output logic [7:0] switch_out,
  output logic [7:0] detect_ctl,
  output logic [3:0] syn_busy
);
  logic [7:0] data_s1_reg, data_s2_reg;
  logic [2:0] addr_s1_reg, addr_s2_reg;
  logic strb_s1_reg, strb_s2_reg, strb_d_reg;
  logic [3:0] lock_s1_reg, lock_s2_reg;
  logic [7:0] ind_set_s1_reg, ind_set_s2_reg;
  logic [7:0] ind_clr_s1_reg, ind_clr_s2_reg;
  logic write;
  logic [7:0] port_hit;
  logic [5:0] sec_lamp;
  logic [SYN_BITS-1:0] syn_word_reg;
  logic [3:0] syn_go_reg;
  logic [7:0] relay_cmd_set_reg, relay_cmd_clr_reg;
  logic [15:0] led_user_reg;
  logic [15:0] lamp_next;
  logic [1:0] box_src;
  logic [15:0] pulse_cnt_reg;
  logic [3:0] busy_w, ser_clk_w, ser_data_w, ser_load_w;

  // Host bus pins; read only once the strobe edge has passed both stages
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_s1_reg <= BYTE_RESET;
      data_s2_reg <= BYTE_RESET;
      addr_s1_reg <= 3'h0;
      addr_s2_reg <= 3'h0;
    end else begin
      data_s1_reg <= host_data;
      data_s2_reg <= data_s1_reg;
      addr_s1_reg <= host_addr;
      addr_s2_reg <= addr_s1_reg;
    end
  end

  // Strobe synchroniser and edge history; idle level is low
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strb_s1_reg <= 1'b0;
      strb_s2_reg <= 1'b0;
      strb_d_reg <= 1'b0;
    end else begin
      strb_s1_reg <= host_strobe;
      strb_s2_reg <= strb_s1_reg;
      strb_d_reg <= strb_s2_reg;
    end
  end

  // Lock and relay indicator sense pins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lock_s1_reg <= 4'h0;
      lock_s2_reg <= 4'h0;
      ind_set_s1_reg <= BYTE_RESET;
      ind_set_s2_reg <= BYTE_RESET;
      ind_clr_s1_reg <= BYTE_RESET;
      ind_clr_s2_reg <= BYTE_RESET;
    end else begin
      lock_s1_reg <= pll_lock;
      lock_s2_reg <= lock_s1_reg;
      ind_set_s1_reg <= relay_ind_set;
      ind_set_s2_reg <= ind_set_s1_reg;
      ind_clr_s1_reg <= relay_ind_clr;
      ind_clr_s2_reg <= ind_clr_s1_reg;
    end
  end

  // Rising strobe edge; data and address are settled by then
  assign write = strb_s2_reg & ~strb_d_reg;

  // One-hot port select: a write reaches exactly one port
  genvar pi;
  generate
    for (pi = 0; pi < 8; pi++) begin : g_port
      assign port_hit[pi] = write && addr_s2_reg == 3'(pi);
    end
  endgenerate

  // Synthesizer word shifts in a byte at a time, MSB byte first
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      syn_word_reg <= SHIFT_RESET;
    end else if (port_hit[PORT_SYN_DATA]) begin
      syn_word_reg <= {syn_word_reg[SYN_BITS-9:0], data_s2_reg};
    end
  end

  // Go port starts idle streams; go bits for busy streams are dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      syn_go_reg <= 4'h0;
    end else if (port_hit[PORT_SYN_GO]) begin
      syn_go_reg <= data_s2_reg[3:0] & ~busy_w;
    end else begin
      syn_go_reg <= 4'h0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_syn
      ifpc_ser u_ser (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(syn_go_reg[gi]),
        .word(syn_word_reg),
        .busy(busy_w[gi]),
        .ser_clk(ser_clk_w[gi]),
        .ser_data(ser_data_w[gi]),
        .ser_load(ser_load_w[gi])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      syn_clk <= 4'h0;
      syn_data <= 4'h0;
      syn_load <= 4'h0;
      syn_busy <= 4'h0;
    end else begin
      syn_clk <= ser_clk_w;
      syn_data <= ser_data_w;
      syn_load <= ser_load_w;
      syn_busy <= busy_w;
    end
  end

  // Relay coil command; a new write replaces the previous one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      relay_cmd_set_reg <= BYTE_RESET;
      relay_cmd_clr_reg <= BYTE_RESET;
    end else if (port_hit[PORT_RELAY_SET]) begin
      relay_cmd_set_reg <= data_s2_reg;
      relay_cmd_clr_reg <= BYTE_RESET;
    end else if (port_hit[PORT_RELAY_CLR]) begin
      relay_cmd_clr_reg <= data_s2_reg;
      relay_cmd_set_reg <= BYTE_RESET;
    end
  end

  // Coil pulse timer, restarted by every relay write
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_reg <= 16'h0000;
    end else if (port_hit[PORT_RELAY_SET] || port_hit[PORT_RELAY_CLR]) begin
      pulse_cnt_reg <= 16'(RELAY_PULSE_CYC);
    end else if (pulse_cnt_reg != 16'h0000) begin
      pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
    end
  end

  // Never energise both coils of one relay
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      relay_set <= BYTE_RESET;
      relay_clr <= BYTE_RESET;
    end else if (pulse_cnt_reg != 16'h0000) begin
      relay_set <= relay_cmd_set_reg & ~relay_cmd_clr_reg;
      relay_clr <= relay_cmd_clr_reg & ~relay_cmd_set_reg;
    end else begin
      relay_set <= BYTE_RESET;
      relay_clr <= BYTE_RESET;
    end
  end

  // Reserved ports: user lamp bytes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      led_user_reg <= 16'h0000;
    end else if (port_hit[PORT_LED_LO]) begin
      led_user_reg[7:0] <= data_s2_reg;
    end else if (port_hit[PORT_LED_HI]) begin
      led_user_reg[15:8] <= data_s2_reg;
    end
  end

  // Reserved ports: switch latch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      switch_out <= BYTE_RESET;
    end else if (port_hit[PORT_SWITCH]) begin
      switch_out <= data_s2_reg;
    end
  end

  // Reserved ports: detector control latch
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      detect_ctl <= BYTE_RESET;
    end else if (port_hit[PORT_DETECT]) begin
      detect_ctl <= data_s2_reg;
    end
  end

  // Source from set-side indicators of the source relays
  assign box_src = {ind_set_s2_reg[RLY_SRC1], ind_set_s2_reg[RLY_SRC0]};

  // Narrow unit: an A and a B lamp for each section output
  genvar si;
  generate
    for (si = 0; si < 3; si++) begin : g_sec
      assign sec_lamp[2*si] = ~ind_set_s2_reg[RLY_SEC_A0+si];
      assign sec_lamp[2*si+1] = ind_set_s2_reg[RLY_SEC_A0+si];
    end
  endgenerate

  // Lamp map: 0-3 unlock, 4-12 source, 13-15 user
  always_comb begin
    lamp_next = led_user_reg;
    lamp_next[3:0] = ~lock_s2_reg;
    lamp_next[12:4] = 9'h000;
    if (!narrow_unit) begin
      if (ind_set_s2_reg[RLY_MODE]) begin
        lamp_next[4] = 1'b1;
      end else begin
        case (box_src)
          SRC_A: lamp_next[5] = 1'b1;
          SRC_B: lamp_next[6] = 1'b1;
          SRC_ZERO: lamp_next[7] = 1'b1;
          default: lamp_next[8] = 1'b1;
        endcase
      end
    end else begin
      // Section A/B pairs, then box B, zero, test
      lamp_next[9:4] = sec_lamp;
      lamp_next[10] = box_src == SRC_B;
      lamp_next[11] = box_src == SRC_ZERO;
      lamp_next[12] = box_src == SRC_TEST;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lamp <= 16'h0000;
    end else begin
      lamp <= lamp_next;
    end
  end

  // Readback mux
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= BYTE_RESET;
    end else begin
      case (rd_sel)
        RB_LOCK: rd_data <= {busy_w, lock_s2_reg};
        RB_RELAY_SET: rd_data <= ind_set_s2_reg;
        RB_RELAY_CLR: rd_data <= ind_clr_s2_reg;
        RB_LED_LO: rd_data <= lamp[7:0];
        RB_LED_HI: rd_data <= lamp[15:8];
        RB_SRC: rd_data <= {6'h00, box_src};
        default: rd_data <= BYTE_RESET;
      endcase
    end
  end
endmodule : ifpc_port

//--- verif/ifpc_port_props.sv
/*
 Assertion checker for the control port, bound to ifpc_port.
 Assumes the host holds strobe high at least six cycles.
*/
`timescale 1ns/1ps
module ifpc_port_props import ifpc_pkg::*; (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [2:0] host_addr,
  input wire logic host_strobe,
  input wire logic [2:0] rd_sel,
  input wire logic [3:0] pll_lock,
  input wire logic [7:0] relay_ind_set,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] syn_clk,
  input wire logic [3:0] syn_data,
  input wire logic [3:0] syn_load,
  input wire logic [3:0] syn_busy,
  input wire logic [7:0] relay_set,
  input wire logic [7:0] relay_clr,
  input wire logic [15:0] lamp,
  input wire logic [7:0] switch_out,
  input wire logic [7:0] detect_ctl
);
  int unsigned coil_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Length of the running coil pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      coil_cnt <= 0;
    else if (|relay_set)
      coil_cnt <= coil_cnt + 1;
    else
      coil_cnt <= 0;
  end
  AST_COIL_EXCL: assert property ((relay_set & relay_clr) == 8'h00)
    else $error("both coils driven");
  AST_COIL_LEN: assert property ($fell(|relay_set) |->
    coil_cnt == RELAY_PULSE_CYC) else $error("coil pulse length wrong");
  AST_COIL_CAUSE: assert property ($rose(relay_set[0]) |->
    $past(host_strobe) && $past(host_addr) == PORT_RELAY_SET)
    else $error("coil pulse without set write");
  AST_ALARM: assert property (($stable(pll_lock))[*8] |->
    lamp[3:0] == ~pll_lock) else $error("alarm lamps wrong");
  AST_SWITCH: assert property ($changed(switch_out) |->
    $past(host_strobe) && $past(host_addr) == PORT_SWITCH)
    else $error("switch latch changed without write");
  AST_DETECT: assert property ($changed(detect_ctl) |->
    $past(host_strobe) && $past(host_addr) == PORT_DETECT)
    else $error("detector latch changed without write");
  AST_CLK_HIGH: assert property ($rose(syn_clk[0]) |->
    (syn_clk[0])[*8] ##0 syn_busy[0]) else $error("serial clock high short");
  AST_DATA_HOLD: assert property (syn_clk[0] |-> $stable(syn_data[0]))
    else $error("serial data moved while clock high");
  AST_LOAD: assert property ($rose(syn_load[0]) |->
    (syn_load[0] && !syn_clk[0])[*8]) else $error("load pulse wrong");
  AST_READBACK: assert property (
    ($stable(rd_sel) && rd_sel == RB_RELAY_SET && $stable(relay_ind_set))[*6]
    |-> rd_data == relay_ind_set) else $error("readback wrong");
  cover property ($rose(syn_load[0]));
  cover property ($fell(|relay_set));
  cover property ($changed(detect_ctl));
endmodule : ifpc_port_props

bind ifpc_port ifpc_port_props ifpc_port_props_i (.sys_clk, .nrst,
  .host_addr, .host_strobe, .rd_sel, .pll_lock, .relay_ind_set, .rd_data,
  .syn_clk, .syn_data, .syn_load, .syn_busy, .relay_set, .relay_clr, .lamp,
  .switch_out, .detect_ctl);

//--- verif/ifpc_host_model.sv
/*
 Host I/O card model: strobed parallel writes.
 Assumes sys_clk only paces the model; bus is invalid between writes.
*/
`timescale 1ns/1ps
module ifpc_host_model import ifpc_pkg::*; (
  input wire logic sys_clk,
  output logic [7:0] host_data,
  output logic [2:0] host_addr,
  output logic host_strobe
);
  initial begin
    host_data = 8'h00;
    host_addr = 3'h0;
    host_strobe = 1'b0;
  end
  // Strobe held hi cycles; large hi gives a slow host
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input int hi);
    @(posedge sys_clk);
    host_addr <= a;
    host_data <= d;
    repeat (4) @(posedge sys_clk);
    host_strobe <= 1'b1;
    repeat (hi) @(posedge sys_clk);
    host_strobe <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Hold over: lines no longer carry the word
    host_addr <= ~a;
    host_data <= ~d;
  endtask : wr
endmodule : ifpc_host_model

//--- verif/ifpc_port_tb.sv
/*
 Self-checking bench for ifpc_port.
 Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps
module ifpc_port_tb import ifpc_pkg::*;;
  logic sys_clk, nrst, narrow_unit;
  logic [7:0] host_data, relay_ind_set, relay_ind_clr, rd_data;
  logic [7:0] relay_set, relay_clr, switch_out, detect_ctl;
  logic [2:0] host_addr, rd_sel;
  logic host_strobe;
  logic [3:0] pll_lock, syn_clk, syn_data, syn_load, syn_busy;
  logic [15:0] lamp;
  int n_errors = 0;
  int samples_checked = 0;

  ifpc_host_model ifpc_host_model_i (.sys_clk, .host_data, .host_addr,
    .host_strobe);
  ifpc_port ifpc_port_i (.sys_clk, .nrst, .host_data, .host_addr,
    .host_strobe, .rd_sel, .narrow_unit, .pll_lock, .relay_ind_set,
    .relay_ind_clr, .rd_data, .syn_clk, .syn_data, .syn_load, .relay_set,
    .relay_clr, .lamp, .switch_out, .detect_ctl, .syn_busy);

  task automatic chk(input string what, input logic [23:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done;
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic t_reset;
    chk("syn_busy", 24'(syn_busy), 24'h00_0000);
    chk("coils", 24'({relay_set, relay_clr}), 24'h00_0000);
    repeat (8) @(posedge sys_clk);
    chk("alarms", 24'(lamp[3:0]), 24'h00_000F);
    pll_lock <= 4'b0101;
    rd_sel <= RB_LOCK;
    repeat (8) @(posedge sys_clk);
    chk("alarms", 24'(lamp[3:0]), 24'h00_000A);
    chk("lock_rb", 24'(rd_data), 24'h00_0005);
  endtask : t_reset

  task automatic t_ports;
    ifpc_host_model_i.wr(PORT_SWITCH, 8'hA5, 6);
    chk("switch", 24'(switch_out), 24'h00_00A5);
    chk("detect", 24'(detect_ctl), 24'h00_0000);
    ifpc_host_model_i.wr(PORT_DETECT, 8'h3C, 20);
    chk("detect", 24'(detect_ctl), 24'h00_003C);
    chk("switch", 24'(switch_out), 24'h00_00A5);
  endtask : t_ports

  task automatic t_relay;
    relay_ind_set <= 8'h5A;
    relay_ind_clr <= 8'hA5;
    narrow_unit <= 1'b1;
    ifpc_host_model_i.wr(PORT_RELAY_SET, 8'h01, 6);
    chk("mode_set", 24'(relay_set), 24'h00_0001);
    chk("narrow_lamps", 24'(lamp[12:4]), 24'h00_005A);
    chk("clr", 24'(relay_clr), 24'h00_0000);
    repeat (RELAY_PULSE_CYC) @(posedge sys_clk);
    chk("set_end", 24'(relay_set), 24'h00_0000);
    ifpc_host_model_i.wr(PORT_RELAY_CLR, 8'h02, 6);
    chk("src_clr", 24'(relay_clr), 24'h00_0002);
    rd_sel <= RB_RELAY_SET;
    repeat (8) @(posedge sys_clk);
    chk("ind_set", 24'(rd_data), 24'h00_005A);
    rd_sel <= RB_RELAY_CLR;
    repeat (RELAY_PULSE_CYC) @(posedge sys_clk);
    chk("ind_clr", 24'(rd_data), 24'h00_00A5);
    chk("clr_end", 24'(relay_clr), 24'h00_0000);
  endtask : t_relay

  task automatic t_lamps;
    narrow_unit <= 1'b0;
    relay_ind_set <= 8'h06;
    rd_sel <= RB_SRC;
    repeat (8) @(posedge sys_clk);
    chk("wide_zero", 24'(lamp[12:4]), 24'h00_0008);
    chk("src_rb", 24'(rd_data), 24'(SRC_ZERO));
    relay_ind_set <= 8'h01;
    repeat (8) @(posedge sys_clk);
    chk("wide_mode", 24'(lamp[12:4]), 24'h00_0001);
    ifpc_host_model_i.wr(PORT_LED_HI, 8'hE0, 6);
    chk("user_lamps", 24'(lamp[15:13]), 24'h00_0007);
  endtask : t_lamps

  task automatic t_syn;
    logic [23:0] got = '0;
    logic prv = 1'b0;
    int rises = 0;
    int loads = 0;
    ifpc_host_model_i.wr(PORT_SYN_DATA, 8'hA5, 6);
    ifpc_host_model_i.wr(PORT_SYN_DATA, 8'h0F, 6);
    ifpc_host_model_i.wr(PORT_SYN_DATA, 8'h3C, 6);
    ifpc_host_model_i.wr(PORT_SYN_GO, 8'h05, 6);
    for (int i = 0; i < 1500; i++) begin
      @(posedge sys_clk);
      #1;
      if (syn_clk[2] && !prv) begin
        got = {got[22:0], syn_data[2]};
        rises++;
      end
      prv = syn_clk[2];
      loads += int'(syn_load[2]);
    end
    chk("syn_word", got, 24'hA5_0F3C);
    chk("syn_bits", 24'(rises), 24'(SYN_BITS));
    chk("syn_load", 24'(loads), 24'(SER_HALF_CYC));
    chk("syn_busy", 24'(syn_busy), 24'h00_0000);
  endtask : t_syn

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    n_errors++;
    test_done();
  end

  initial begin
    nrst = 1'b0;
    narrow_unit = 1'b0;
    pll_lock = 4'h0;
    rd_sel = 3'h0;
    relay_ind_set = 8'h00;
    relay_ind_clr = 8'h00;
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_ports();
    t_relay();
    t_lamps();
    t_syn();
    test_done();
  end
endmodule : ifpc_port_tb
